/* rtl/serial_config_defs.vh */
// Purpose: Constants for the serial configuration port and register bank
// Assumes: 24-bit frames, msb first, 8-bit registers
// Notes: Offsets are 12-bit header addresses
// Function
// - Bits accepted only while select is low
// - Data sampled on each serial clock rise
// - Frame commits on every 24th rise
// - Partial frame dropped when select rises
// - Back-to-back frames each independent access
// - Any serial rate up to 12 MHz
// - Read flag set means no write
// - Read data launched on falling edges
// - Power-down waits for running sampling clock
// - Works with defaults, pins control power
// - Power-up defaults give documented configuration
// - Averaging combines both channel samples
// - Average goes to lane A or filter A
// - Soft reset bit restores defaults, self-clears
`ifndef SERIAL_CONFIG_DEFS_VH
`define SERIAL_CONFIG_DEFS_VH
`define FRAME_BITS 24
`define HDR_BITS 16
`define ADDR_SOFT_RESET 12'h000
`define ADDR_IFACE_SEL 12'h007
`define ADDR_BLOCK_PDN 12'h008
`define ADDR_LANE_PDN 12'h009
`define ADDR_PDN_MASK 12'h00D
`define ADDR_SYNC_REF 12'h00E
`define ADDR_INPUT_AZ 12'h011
`define ADDR_FUSE_LOAD 12'h013
`define ADDR_PAT_LOW 12'h014
`define ADDR_PAT_MID 12'h015
`define ADDR_PAT_SEL 12'h016
`define ADDR_FRAME_CLK 12'h019
`define ADDR_SWING 12'h01A
`define ADDR_RESOLUTION 12'h01B
`define ADDR_LANE_DELAY 12'h01E
`define ADDR_FRAME_PAT 12'h020
`define ADDR_AVG_CTRL 12'h024
`define BIT_SOFT_RESET 0
`define BIT_GLOBAL_PDN 0
`define BIT_AVG_ENABLE 5
`define BIT_AVG_TO_FILTER 4
`define REG_RESET_VAL 8'h00
`define CLK_TIMEOUT_CYC 8'h10
`endif

/* rtl/edge_sync.v */
// Purpose: Two-stage synchroniser with rise and fall pulses
// Assumes: Input is asynchronous to i_clk
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
module edge_sync #(
    // Idle level of the pin, so that release of reset shows no false edge
    parameter [0:0] RESET_LEVEL = 1'b1
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_async,
    output wire o_level,
    output wire o_rise,
    output wire o_fall
);
    reg meta_q;
    reg sync_q;
    reg last_q;
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            meta_q <= RESET_LEVEL;
            sync_q <= RESET_LEVEL;
            last_q <= RESET_LEVEL;
        end else if (i_ce) begin
            meta_q <= i_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign o_level = sync_q;
    assign o_rise = sync_q & ~last_q;
    assign o_fall = ~sync_q & last_q;
endmodule

/* rtl/channel_average.v */
// Purpose: Sample-by-sample average of two channel results
// Assumes: Both samples share one valid strobe
// Notes: Sum is widened one bit so the halving never overflows
`timescale 1ns/1ps
module channel_average #(
    parameter WIDTH = 16
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_enable,
    input wire i_to_filter,
    input wire i_valid,
    input wire [WIDTH-1:0] i_sample_a,
    input wire [WIDTH-1:0] i_sample_b,
    output reg [WIDTH-1:0] o_lane_a,
    output reg [WIDTH-1:0] o_lane_b,
    output reg [WIDTH-1:0] o_filter_a,
    output reg [WIDTH-1:0] o_filter_b,
    output reg o_valid
);
    wire [WIDTH:0] sum;
    wire [WIDTH-1:0] avg;
    // Signed sum, two's complement samples
    assign sum = {i_sample_a[WIDTH-1], i_sample_a} + {i_sample_b[WIDTH-1], i_sample_b};
    assign avg = sum[WIDTH:1];
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_lane_a <= {WIDTH{1'b0}};
            o_lane_b <= {WIDTH{1'b0}};
            o_filter_a <= {WIDTH{1'b0}};
            o_filter_b <= {WIDTH{1'b0}};
            o_valid <= 1'b0;
        end else if (i_ce) begin
            o_valid <= i_valid;
            if (i_valid) begin
                o_lane_b <= i_sample_b;
                o_filter_b <= i_sample_b;
                if (i_enable && !i_to_filter) begin
                    o_lane_a <= avg;
                    o_filter_a <= i_sample_a;
                end else if (i_enable) begin
                    o_lane_a <= i_sample_a;
                    o_filter_a <= avg;
                end else begin
                    o_lane_a <= i_sample_a;
                    o_filter_a <= i_sample_a;
                end
            end
        end
    end
endmodule

/* rtl/serial_config_port.v */
// Purpose: Three-wire serial configuration port with register bank
// Assumes: i_clk at 50 MHz, serial clock at most 12 MHz
// Notes: Serial pins are oversampled; data pin output enable is active low
`timescale 1ns/1ps
`include "serial_config_defs.vh"
module serial_config_port #(
    parameter WIDTH = 16
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_ce,
    input wire i_serial_select_n,
    input wire i_serial_clk,
    input wire i_serial_data,
    output reg o_serial_data,
    output reg o_serial_data_oe_n,
    input wire i_powerdown_sync_pin,
    input wire i_reference_select_pin,
    input wire i_sample_clk,
    input wire i_sample_valid,
    input wire [WIDTH-1:0] i_sample_a,
    input wire [WIDTH-1:0] i_sample_b,
    output wire [WIDTH-1:0] o_lane_a,
    output wire [WIDTH-1:0] o_lane_b,
    output wire [WIDTH-1:0] o_filter_a,
    output wire [WIDTH-1:0] o_filter_b,
    output wire o_out_valid,
    output reg o_powerdown,
    output reg o_internal_reference,
    output reg o_filter_enable,
    output reg o_offset_binary,
    output reg [7:0] o_iface_mapping,
    output reg o_fuse_load_cmd
);
    wire sel_lvl;
    wire sel_rise;
    wire sck_rise;
    wire sck_fall;
    wire sdi_lvl;
    wire smp_rise;
    edge_sync u_sel (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(i_serial_select_n),
        .o_level(sel_lvl),
        .o_rise(sel_rise),
        .o_fall()
    );
    // Serial clock idles low; each phase must last about two system clocks
    edge_sync #(
        .RESET_LEVEL(1'b0)
    ) u_sck (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(i_serial_clk),
        .o_level(),
        .o_rise(sck_rise),
        .o_fall(sck_fall)
    );
    edge_sync u_sdi (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(i_serial_data),
        .o_level(sdi_lvl),
        .o_rise(),
        .o_fall()
    );
    edge_sync #(
        .RESET_LEVEL(1'b0)
    ) u_smp (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_async(i_sample_clk),
        .o_level(),
        .o_rise(smp_rise),
        .o_fall()
    );
    wire pdn_pin;
    wire ref_pin;
    reg pdn_m_q;
    reg pdn_s_q;
    reg ref_m_q;
    reg ref_s_q;
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            pdn_m_q <= 1'b0;
            pdn_s_q <= 1'b0;
            ref_m_q <= 1'b1;
            ref_s_q <= 1'b1;
        end else if (i_ce) begin
            pdn_m_q <= i_powerdown_sync_pin;
            pdn_s_q <= pdn_m_q;
            ref_m_q <= i_reference_select_pin;
            ref_s_q <= ref_m_q;
        end
    end
    assign pdn_pin = pdn_s_q;
    assign ref_pin = ref_s_q;

    // Frame receiver
    localparam [4:0] LAST_BIT = `FRAME_BITS - 1;
    localparam [4:0] HDR_LAST = `HDR_BITS - 1;
    reg [4:0] cnt_q;
    reg [22:0] shf_q;
    reg rd_q;
    reg [7:0] rd_data_q;
    reg [2:0] rd_idx_q;
    wire active;
    wire bit_take;
    wire frame_done;
    wire [23:0] frame;
    wire [11:0] f_addr;
    wire [7:0] f_data;
    wire f_read;
    wire hdr_done;
    assign active = !sel_lvl;
    assign bit_take = active && sck_rise;
    assign frame_done = bit_take && (cnt_q == LAST_BIT);
    assign frame = {shf_q, sdi_lvl};
    assign f_addr = frame[19:8];
    assign f_data = frame[7:0];
    assign f_read = frame[23];
    assign hdr_done = bit_take && (cnt_q == HDR_LAST);

    // Register bank
    reg [7:0] regs_q [0:16];
    reg wr_en;
    reg [4:0] wr_idx;
    reg soft_rst_q;
    integer k;
    always @* begin
        wr_idx = 5'd0;
        wr_en = 1'b1;
        case (f_addr)
            `ADDR_SOFT_RESET: wr_idx = 5'd0;
            `ADDR_IFACE_SEL: wr_idx = 5'd1;
            `ADDR_BLOCK_PDN: wr_idx = 5'd2;
            `ADDR_LANE_PDN: wr_idx = 5'd3;
            `ADDR_PDN_MASK: wr_idx = 5'd4;
            `ADDR_SYNC_REF: wr_idx = 5'd5;
            `ADDR_INPUT_AZ: wr_idx = 5'd6;
            `ADDR_FUSE_LOAD: wr_idx = 5'd7;
            `ADDR_PAT_LOW: wr_idx = 5'd8;
            `ADDR_PAT_MID: wr_idx = 5'd9;
            `ADDR_PAT_SEL: wr_idx = 5'd10;
            `ADDR_FRAME_CLK: wr_idx = 5'd11;
            `ADDR_SWING: wr_idx = 5'd12;
            `ADDR_RESOLUTION: wr_idx = 5'd13;
            `ADDR_LANE_DELAY: wr_idx = 5'd14;
            `ADDR_FRAME_PAT: wr_idx = 5'd15;
            `ADDR_AVG_CTRL: wr_idx = 5'd16;
            default: wr_en = 1'b0;
        endcase
    end
    // Address decode uses the header bits still in the shifter at bit 16
    wire [11:0] hdr_addr;
    assign hdr_addr = {shf_q[10:0], sdi_lvl};

    always @(posedge i_clk) begin
        if (!i_resetn) begin
            cnt_q <= 5'd0;
            shf_q <= 23'd0;
            soft_rst_q <= 1'b0;
            for (k = 0; k < 17; k = k + 1) begin
                regs_q[k] <= `REG_RESET_VAL;
            end
        end else if (i_ce) begin
            if (soft_rst_q) begin
                soft_rst_q <= 1'b0;
                for (k = 0; k < 17; k = k + 1) begin
                    regs_q[k] <= `REG_RESET_VAL;
                end
            end
            if (sel_rise) begin
                cnt_q <= 5'd0;
            end else if (bit_take) begin
                shf_q <= frame[22:0];
                cnt_q <= frame_done ? 5'd0 : cnt_q + 5'd1;
            end
            if (frame_done && !f_read && wr_en) begin
                if (wr_idx == 5'd0) begin
                    soft_rst_q <= f_data[`BIT_SOFT_RESET];
                end else begin
                    regs_q[wr_idx] <= f_data;
                end
            end
        end
    end

    // Readback shifter; pin released outside the read data phase
    reg [7:0] rd_word;
    always @* begin
        case (hdr_addr)
            `ADDR_SOFT_RESET: rd_word = regs_q[0];
            `ADDR_IFACE_SEL: rd_word = regs_q[1];
            `ADDR_BLOCK_PDN: rd_word = regs_q[2];
            `ADDR_LANE_PDN: rd_word = regs_q[3];
            `ADDR_PDN_MASK: rd_word = regs_q[4];
            `ADDR_SYNC_REF: rd_word = regs_q[5];
            `ADDR_INPUT_AZ: rd_word = regs_q[6];
            `ADDR_FUSE_LOAD: rd_word = regs_q[7];
            `ADDR_PAT_LOW: rd_word = regs_q[8];
            `ADDR_PAT_MID: rd_word = regs_q[9];
            `ADDR_PAT_SEL: rd_word = regs_q[10];
            `ADDR_FRAME_CLK: rd_word = regs_q[11];
            `ADDR_SWING: rd_word = regs_q[12];
            `ADDR_RESOLUTION: rd_word = regs_q[13];
            `ADDR_LANE_DELAY: rd_word = regs_q[14];
            `ADDR_FRAME_PAT: rd_word = regs_q[15];
            `ADDR_AVG_CTRL: rd_word = regs_q[16];
            default: rd_word = 8'h00;
        endcase
    end
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            rd_q <= 1'b0;
            rd_data_q <= 8'h00;
            rd_idx_q <= 3'd7;
            o_serial_data <= 1'b0;
            o_serial_data_oe_n <= 1'b1;
        end else if (i_ce) begin
            if (sel_rise || frame_done || !active) begin
                rd_q <= 1'b0;
                o_serial_data_oe_n <= 1'b1;
            end else if (hdr_done) begin
                rd_q <= shf_q[14];
                rd_data_q <= rd_word;
                rd_idx_q <= 3'd7;
            end else if (rd_q && sck_fall) begin
                o_serial_data <= rd_data_q[rd_idx_q];
                o_serial_data_oe_n <= 1'b0;
                rd_idx_q <= rd_idx_q - 3'd1;
            end
        end
    end

    // Power-down waits for a sampling clock edge; a stopped clock leaves it pending
    wire pdn_req;
    assign pdn_req = pdn_pin | regs_q[2][`BIT_GLOBAL_PDN];
    always @(posedge i_clk) begin
        if (!i_resetn) begin
            o_powerdown <= 1'b0;
            o_internal_reference <= 1'b0;
            o_filter_enable <= 1'b0;
            o_offset_binary <= 1'b0;
            o_iface_mapping <= 8'h00;
            o_fuse_load_cmd <= 1'b0;
        end else if (i_ce) begin
            if (smp_rise) begin
                o_powerdown <= pdn_req;
            end
            o_internal_reference <= !ref_pin | regs_q[5][3];
            o_filter_enable <= regs_q[16][1];
            o_offset_binary <= 1'b0;
            o_iface_mapping <= regs_q[1];
            o_fuse_load_cmd <= regs_q[7][0];
        end
    end

    channel_average #(
        .WIDTH(WIDTH)
    ) u_avg (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_ce(i_ce),
        .i_enable(regs_q[16][`BIT_AVG_ENABLE]),
        .i_to_filter(regs_q[16][`BIT_AVG_TO_FILTER]),
        .i_valid(i_sample_valid),
        .i_sample_a(i_sample_a),
        .i_sample_b(i_sample_b),
        .o_lane_a(o_lane_a),
        .o_lane_b(o_lane_b),
        .o_filter_a(o_filter_a),
        .o_filter_b(o_filter_b),
        .o_valid(o_out_valid)
    );
endmodule

/* sim/host_model.sv */
// Purpose: Host side of the three-wire configuration link
// Assumes: Link clock idles low outside frames, 160 ns period
// Notes: During read data the host lets go; a toggling level stands in
`timescale 1ns/1ps
module host_model (
    output reg o_select_n,
    output reg o_sclk,
    output reg o_data,
    input wire i_data
);
    reg [7:0] rd;
    event got;
    initial begin
        o_select_n = 1'b1;
        o_sclk = 1'b0;
        o_data = 1'b0;
    end
    // Frames chain inside one select window when done is not called between
    task xfer(input [23:0] w, input integer n, input sel);
        integer i;
        begin
            o_select_n = sel;
            #40;
            for (i = 23; i > 23 - n; i = i - 1) begin
                if (w[23] && i < 8) o_data = ~o_data;
                else o_data = w[i];
                #80 o_sclk = 1'b1;
                if (i < 8) rd[i] = i_data;
                if (i == 0 && w[23]) -> got;
                #80 o_sclk = 1'b0;
            end
        end
    endtask
    task done;
        begin
            #40 o_select_n = 1'b1;
            #200;
        end
    endtask
endmodule

/* sim/serial_config_port_asserts.sv */
// Purpose: Port-level checks for the serial configuration port
// Assumes: register bank at reset values unless written
// Notes: Serial timing figures allow for the oversampling delay
`timescale 1ns/1ps
module serial_config_port_asserts #(
    parameter WIDTH = 16
) (
    input wire i_clk,
    input wire i_resetn,
    input wire i_serial_select_n,
    input wire i_serial_clk,
    input wire o_serial_data,
    input wire o_serial_data_oe_n,
    input wire i_powerdown_sync_pin,
    input wire i_reference_select_pin,
    input wire i_sample_clk,
    input wire i_sample_valid,
    input wire o_out_valid,
    input wire o_powerdown,
    input wire o_internal_reference,
    input wire o_offset_binary,
    input wire [7:0] o_iface_mapping,
    input wire o_fuse_load_cmd
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    property p_idle_release;
        i_serial_select_n [*5] |-> o_serial_data_oe_n;
    endproperty
    a_idle_release: assert property (p_idle_release)
        else $error("data pin driven while deselected");
    property p_format;
        o_offset_binary == 1'b0;
    endproperty
    a_format: assert property (p_format)
        else $error("output format not two's complement");
    property p_pdn_gated;
        !i_sample_clk [*8] |=> $stable(o_powerdown);
    endproperty
    a_pdn_gated: assert property (p_pdn_gated)
        else $error("power-down moved without sampling clock");
    property p_pdn_pin;
        i_powerdown_sync_pin [*8] ##1 $rose(i_sample_clk) |-> ##[1:6] o_powerdown;
    endproperty
    a_pdn_pin: assert property (p_pdn_pin)
        else $error("power-down pin not honoured");
    property p_valid_cause;
        o_out_valid |-> $past(i_sample_valid) || $past(i_sample_valid, 2);
    endproperty
    a_valid_cause: assert property (p_valid_cause)
        else $error("output valid without a sample");
    property p_launch;
        $changed(o_serial_data) && !o_serial_data_oe_n && $past(!o_serial_data_oe_n)
            |-> !$past(i_serial_clk, 2);
    endproperty
    a_launch: assert property (p_launch)
        else $error("read bit not launched after a fall");
    property p_idle_stable;
        i_serial_select_n [*8] |=> $stable(o_iface_mapping) && $stable(o_fuse_load_cmd);
    endproperty
    a_idle_stable: assert property (p_idle_stable)
        else $error("register changed while deselected");
    property p_ref_pin;
        !i_reference_select_pin [*4] |-> o_internal_reference;
    endproperty
    a_ref_pin: assert property (p_ref_pin)
        else $error("reference pin not honoured");
    c_read: cover property ($fell(o_serial_data_oe_n));
    c_pdn: cover property ($rose(o_powerdown));
    c_avg: cover property (o_out_valid);
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench for the serial configuration port
// Assumes: clock enable held high except in the freeze check
// Notes: Read bytes and averages are compared through expectation queues
`timescale 1ns/1ps
module tb;
    localparam [191:0] ADDRS = {12'h000, 12'h007, 12'h008, 12'h009, 12'h00D, 12'h00E,
        12'h011, 12'h013, 12'h014, 12'h015, 12'h016, 12'h019, 12'h01A, 12'h01B,
        12'h01E, 12'h020};
    reg i_clk = 1'b0;
    reg i_resetn = 1'b0;
    reg ce = 1'b1;
    reg pdn = 1'b0;
    reg ref_sel = 1'b1;
    reg smp = 1'b0;
    reg smp_run = 1'b0;
    reg sv = 1'b0;
    reg [15:0] sa = 16'h0000;
    reg [15:0] sb = 16'h0000;
    reg [7:0] v [0:15];
    reg [7:0] rq [$];
    reg [16:0] aq [$];
    reg [16:0] e;
    integer n_errors = 0;
    integer checked = 0;
    integer k;
    wire sel_n, sclk, h_data, dut_data, oe_n, valid, pdn_out, ref_out;
    wire [15:0] lane_a, filt_a;
    wire sdio = oe_n ? h_data : dut_data;
    initial forever #10 i_clk = ~i_clk;
    // Half period of three clocks keeps every edge on a falling edge of i_clk
    always #60 smp = smp_run ? ~smp : 1'b0;
    host_model host_model_inst (.o_select_n(sel_n), .o_sclk(sclk), .o_data(h_data),
        .i_data(sdio));
    serial_config_port #(.WIDTH(16)) serial_config_port_inst (.i_clk(i_clk),
        .i_resetn(i_resetn), .i_ce(ce), .i_serial_select_n(sel_n), .i_serial_clk(sclk),
        .i_serial_data(sdio), .o_serial_data(dut_data), .o_serial_data_oe_n(oe_n),
        .i_powerdown_sync_pin(pdn), .i_reference_select_pin(ref_sel), .i_sample_clk(smp),
        .i_sample_valid(sv), .i_sample_a(sa), .i_sample_b(sb), .o_lane_a(lane_a),
        .o_lane_b(), .o_filter_a(filt_a), .o_filter_b(), .o_out_valid(valid),
        .o_powerdown(pdn_out), .o_internal_reference(ref_out), .o_filter_enable(),
        .o_offset_binary(), .o_iface_mapping(), .o_fuse_load_cmd());
    task check(input [15:0] seen, input [15:0] exp);
        begin
            checked = checked + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task print_verdict;
        begin
            if (n_errors == 0 && checked > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        host_model_inst.xfer({4'h0, a, d}, 24, 1'b0);
    endtask
    task rd(input [11:0] a, input [7:0] x);
        begin
            rq.push_back(x);
            host_model_inst.xfer({4'h8, a, 8'h00}, 24, 1'b0);
        end
    endtask
    task samp(input route, input [15:0] a, input [15:0] b);
        reg signed [16:0] s;
        begin
            s = $signed(a) + $signed(b);
            aq.push_back({route, s[16:1]});
            @(negedge i_clk);
            sa = a;
            sb = b;
            sv = 1'b1;
            @(negedge i_clk);
            sv = 1'b0;
            repeat (4) @(negedge i_clk);
        end
    endtask
    task wait_clk(input integer n);
        repeat (n) @(negedge i_clk);
    endtask
    always @(host_model_inst.got) check(host_model_inst.rd, rq.pop_front());
    always @(negedge i_clk) begin
        if (valid === 1'b1) begin
            e = aq.pop_front();
            check(e[16] ? filt_a : lane_a, e[15:0]);
        end
    end
    initial begin
        repeat (100000) @(posedge i_clk);
        n_errors = n_errors + 1;
        print_verdict;
    end
    initial begin
        void'($urandom(32'heacd_2220));
        wait_clk(5);
        i_resetn = 1'b1;
        ref_sel = 1'b0;
        wait_clk(10);
        check(ref_out, 1'b1);
        ref_sel = 1'b1;
        for (k = 0; k < 16; k = k + 1) rd(ADDRS[12*(15-k) +: 12], 8'h00);
        host_model_inst.done;
        for (k = 1; k < 16; k = k + 1) begin
            v[k] = $urandom;
            if (k == 2) v[k] = v[k] | 8'h01;
        end
        wr(12'h007, v[1]);
        wr(12'h013, v[7]);
        for (k = 2; k < 16; k = k + 1) begin
            if (k != 7) wr(ADDRS[12*(15-k) +: 12], v[k]);
        end
        host_model_inst.done;
        check(pdn_out, 1'b0);
        for (k = 1; k < 16; k = k + 1) rd(ADDRS[12*(15-k) +: 12], v[k]);
        host_model_inst.done;
        host_model_inst.xfer({4'h0, 12'h007, ~v[1]}, 20, 1'b0);
        host_model_inst.done;
        host_model_inst.xfer({4'h0, 12'h014, ~v[8]}, 24, 1'b1);
        wr(12'h0FF, 8'h5A);
        wr(12'h015, 8'h3C);
        host_model_inst.xfer({4'h0, 12'h016, 8'h00}, 12, 1'b0);
        host_model_inst.done;
        rd(12'h007, v[1]);
        rd(12'h014, v[8]);
        rd(12'h015, 8'h3C);
        rd(12'h016, v[10]);
        rd(12'h0FF, 8'h00);
        wr(12'h000, 8'h01);
        rd(12'h000, 8'h00);
        rd(12'h007, 8'h00);
        wr(12'h024, 8'h20);
        host_model_inst.done;
        samp(1'b0, 16'h8000, 16'h8000);
        samp(1'b0, 16'h7FFF, 16'h7FFF);
        for (k = 0; k < 4; k = k + 1) samp(1'b0, $urandom, $urandom);
        wr(12'h024, 8'h30);
        host_model_inst.done;
        for (k = 0; k < 4; k = k + 1) samp(1'b1, $urandom, $urandom);
        pdn = 1'b1;
        wait_clk(20);
        check(pdn_out, 1'b0);
        smp_run = 1'b1;
        wait_clk(20);
        check(pdn_out, 1'b1);
        ce = 1'b0;
        pdn = 1'b0;
        wait_clk(20);
        check(pdn_out, 1'b1);
        ce = 1'b1;
        wait_clk(20);
        check(pdn_out, 1'b0);
        check(rq.size(), 16'h0000);
        print_verdict;
    end
endmodule
bind serial_config_port serial_config_port_asserts #(.WIDTH(WIDTH)) chk_inst (.i_clk,
    .i_resetn, .i_serial_select_n, .i_serial_clk, .o_serial_data, .o_serial_data_oe_n,
    .i_powerdown_sync_pin, .i_reference_select_pin, .i_sample_clk, .i_sample_valid,
    .o_out_valid, .o_powerdown, .o_internal_reference, .o_offset_binary, .o_iface_mapping,
    .o_fuse_load_cmd);
